// ===== shared/fifo_pkg.sv
/*
 * constants, field positions and state codes shared by the dual-port fifo core
 * and its testbench.
 * assumes: every file refers to these by package::name, nothing is imported.
 */
`default_nettype none

package fifo_pkg;

   // data path
   localparam int DATA_W    = 36;            // word width on both buses
   localparam int DEPTH_DEF = 512;           // default memory depth in words

   // offset presets picked by the mode pins at reset release
   localparam logic [10:0] PRESET_HI = 11'h040;   // preset of 64
   localparam logic [10:0] PRESET_LO = 11'h008;   // preset of 8

   // write-clock edges between reset release and in-space rising
   localparam int INIT_EDGES = 2;

   // values after reset
   localparam logic NEAR_FULL_RST  = 1'b1;   // near-full is active low, idle high
   localparam logic NEAR_EMPTY_RST = 1'b0;   // near-empty is active low, asserted
   localparam logic MAIL_FLAG_RST  = 1'b1;   // both mail flags idle high
   localparam logic [35:0] WPORT_IDLE = 36'h0_0000_0000;  // write bus drive value

   // write-port sampled control vector layout
   localparam int WC_SEL_N  = 0;
   localparam int WC_DIR    = 1;
   localparam int WC_EN     = 2;
   localparam int WC_MB     = 3;
   localparam int WC_SLOAD  = 4;             // serial load strobe, active low
   localparam int WC_SDATA  = 5;
   localparam int WC_DATA   = 6;
   localparam int WC_W      = WC_DATA + DATA_W;

   // read-port sampled control vector layout
   localparam int RC_SEL_N  = 0;
   localparam int RC_DIR    = 1;
   localparam int RC_EN     = 2;
   localparam int RC_MB     = 3;
   localparam int RC_W      = 4;

   // offset initialisation modes, coded as {sel_hi, sel_lo}
   typedef enum logic [1:0] {
      MODE_PAR = 2'h0,
      MODE_P8  = 2'h1,
      MODE_P64 = 2'h2,
      MODE_SER = 2'h3
   } offset_mode_e;

   // initialisation sequencer, one-hot
   typedef enum logic [4:0] {
      ST_INIT = 5'h01,
      ST_WAIT = 5'h02,
      ST_SER  = 5'h04,
      ST_PAR  = 5'h08,
      ST_RUN  = 5'h10
   } init_state_e;

endpackage : fifo_pkg

`default_nettype wire

// ===== shared/pin_port_if.sv
/*
 * carrier between a pin sampler and the fifo core: one edge pulse of the
 * port clock and the control pins as they stood just before that edge.
 * assumes: both ends run on sys_clk.
 */
`default_nettype none

interface pin_port_if #(
   parameter int W = 1
);
   logic         edge_seen;   // one sys_clk pulse per port clock rising edge
   logic [W-1:0] ctrl;        // pins sampled ahead of that edge

   modport src (output edge_seen, output ctrl);
   modport snk (input edge_seen, input ctrl);
endinterface : pin_port_if

`default_nettype wire

// ===== rtl/pin_sampler.sv
/*
 * samples a port clock pin into sys_clk two flops deep and its control pins three deep,
 * and reports each rising edge of the port clock as a single pulse.
 * assumes: sys_clk is well above twice the port clock rate.
 */
`default_nettype none

module pin_sampler #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic         port_clk,
   input  wire logic [W-1:0] port_pins,
   pin_port_if.src           port
);

   logic [2:0]   clk_q;   // clock pin sync chain plus edge history
   logic [W-1:0] s1_q;    // first sync stage, read only by s2
   logic [W-1:0] s2_q;    // second sync stage
   logic [W-1:0] s3_q;    // one sample older: value ahead of the edge

   if (W < 1) begin : g_bad_width
      $error("pin_sampler width must be at least one");
   end

   // clock pin synchroniser
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         // all ones: a pin that is high at release shows no false edge
         clk_q <= 3'h7;
      end else begin
         clk_q <= {clk_q[1:0], port_clk};
      end
   end

   // control pins, one stage deeper so they show setup-side values; no reset,
   // so a cleared select never turns a bus driver on while reset is held
   always_ff @(posedge sys_clk) begin
      s1_q <= port_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // edge seen on the synchronised stage only, never on the first flop
   assign port.edge_seen = clk_q[1] & ~clk_q[2];
   assign port.ctrl      = s3_q;

endmodule : pin_sampler

`default_nettype wire

// ===== rtl/dual_clock_fifo_offset_flags.sv
/*
 * dual-port 36-bit fifo: write port to read port, offset register setup,
 * output register with fall-through, in-space / out-ready flags.
 * assumes: both port clocks arrive as pins and are oversampled by sys_clk;
 * mailbox and retransmit logic sit outside and share the mailbox selects.
 */
`default_nettype none

module dual_clock_fifo_offset_flags #(
   parameter int DEPTH = fifo_pkg::DEPTH_DEF   // 512, 1024 or 2048 words
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        write_side_clock,
   input  wire logic        read_side_clock,
   input  wire logic        offset_mode_sel_hi,
   input  wire logic        offset_mode_sel_lo,
   input  wire logic        serial_load_n,
   input  wire logic        serial_offset_in,
   input  wire logic        wport_select_n,
   input  wire logic        wport_dir,
   input  wire logic        wport_xfer_en,
   input  wire logic        wport_mailbox_sel,
   input  wire logic [35:0] wport_bus_i,
   output logic      [35:0] wport_bus_o,
   output logic             wport_bus_oe,
   input  wire logic        rport_select_n,
   input  wire logic        rport_dir,
   input  wire logic        rport_xfer_en,
   input  wire logic        rport_mailbox_sel,
   input  wire logic [35:0] rport_bus_i,
   output logic      [35:0] rport_bus_o,
   output logic             rport_bus_oe,
   output logic             in_space_flag,
   output logic             near_full_flag,
   output logic             out_ready_flag,
   output logic             near_empty_flag,
   output logic             mail_to_reader_flag,
   output logic             mail_to_writer_flag
);

   // sizes follow the depth
   localparam int ADDR_W   = $clog2(DEPTH);
   localparam int PTR_W    = ADDR_W + 1;          // extra wrap bit
   localparam int OFF_W    = ADDR_W;              // 9, 10 or 11 offset bits
   localparam int SER_BITS = 2 * OFF_W;           // 18, 20 or 22
   localparam int SCNT_W   = $clog2(SER_BITS + 1);
   localparam logic [PTR_W-1:0]  DEPTH_P   = PTR_W'(DEPTH);
   localparam logic [SCNT_W-1:0] SER_LAST  = SCNT_W'(SER_BITS);
   localparam logic [1:0]        WAIT_LAST = 2'(fifo_pkg::INIT_EDGES - 1);

   if (DEPTH != 512 && DEPTH != 1024 && DEPTH != 2048) begin : g_bad_depth
      $error("fifo depth must be 512, 1024 or 2048");
   end

   // sampled port bundles
   pin_port_if #(.W(fifo_pkg::WC_W)) wr ();
   pin_port_if #(.W(fifo_pkg::RC_W)) rd ();

   pin_sampler #(.W(fifo_pkg::WC_W)) u_wr_sampler (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .port_clk  (write_side_clock),
      .port_pins ({wport_bus_i, serial_offset_in, serial_load_n, wport_mailbox_sel,
                   wport_xfer_en, wport_dir, wport_select_n}),
      .port      (wr.src)
   );

   pin_sampler #(.W(fifo_pkg::RC_W)) u_rd_sampler (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .port_clk  (read_side_clock),
      .port_pins ({rport_mailbox_sel, rport_xfer_en, rport_dir, rport_select_n}),
      .port      (rd.src)
   );

   // storage
   logic [35:0]       mem_q [DEPTH];      // fifo words
   logic [35:0]       dout_q;             // output register

   // pointers and their copies in the opposite port
   logic [PTR_W-1:0]  wptr_q;             // advanced on write edges
   logic [PTR_W-1:0]  rptr_q;             // advanced on read edges
   logic [PTR_W-1:0]  rptr_w1_q;          // read pointer seen by write side
   logic [PTR_W-1:0]  wptr_r1_q;          // write pointer, read stage one
   logic [PTR_W-1:0]  wptr_r2_q;          // write pointer, read stage two

   // offsets and initialisation
   logic [OFF_W-1:0]  off_ae_q;           // near-empty offset
   logic [OFF_W-1:0]  off_af_q;           // near-full offset
   logic [1:0]        mode_s1_q;          // mode pins, first sync stage
   logic [1:0]        mode_s2_q;          // mode pins, second sync stage
   fifo_pkg::offset_mode_e mode_q;        // mode caught after release
   fifo_pkg::init_state_e  st_q;
   fifo_pkg::init_state_e  st_d;
   logic [1:0]        wait_cnt_q;         // write edges since release
   logic              par_cnt_q;          // 0: near-full next, 1: near-empty next
   logic [SCNT_W-1:0] ser_cnt_q;          // serial bits taken

   // flags
   logic              in_space_q;
   logic              near_full_q;
   logic              out_ready_q;
   logic              near_empty_q;

   // decoded port actions
   logic              wr_qual;            // fifo write strobe met
   logic              wr_store;           // word goes to memory
   logic              wr_off_load;        // word goes to an offset
   logic              rd_qual;            // selected fifo read while ready
   logic              rd_avail;           // synced write pointer shows data
   logic              rd_adv;             // new word into output register
   logic [PTR_W-1:0]  wptr_d;
   logic [PTR_W-1:0]  rptr_d;
   logic [PTR_W-1:0]  fill_w;             // fill as the write side sees it
   logic [PTR_W-1:0]  fill_r;             // fill as the read side sees it

   // port decode shared by both directions
   function automatic logic port_go(input logic sel_n, input logic mb,
                                    input logic dir, input logic en);
      port_go = !sel_n && !mb && dir && en;
   endfunction : port_go

   assign wr_qual     = wr.edge_seen && in_space_q
                        && port_go(wr.ctrl[fifo_pkg::WC_SEL_N], wr.ctrl[fifo_pkg::WC_MB],
                                   wr.ctrl[fifo_pkg::WC_DIR], wr.ctrl[fifo_pkg::WC_EN]);
   assign wr_store    = wr_qual && (st_q == fifo_pkg::ST_RUN);
   assign wr_off_load = wr_qual && (st_q == fifo_pkg::ST_PAR);
   assign rd_qual     = rd.edge_seen && out_ready_q
                        && port_go(rd.ctrl[fifo_pkg::RC_SEL_N], rd.ctrl[fifo_pkg::RC_MB],
                                   rd.ctrl[fifo_pkg::RC_DIR], rd.ctrl[fifo_pkg::RC_EN]);
   assign rd_avail    = (wptr_r2_q != rptr_q);
   assign rd_adv      = rd.edge_seen && rd_avail && (!out_ready_q || rd_qual);
   assign wptr_d      = wptr_q + PTR_W'(wr_store);
   assign rptr_d      = rptr_q + PTR_W'(rd_adv);
   assign fill_w      = wptr_d - rptr_w1_q;
   assign fill_r      = wptr_r1_q - rptr_d;

   // mode pins reach logic only after two flops; kept out of reset so the
   // pin levels, not a cleared value, stand in the first cycle after release
   always_ff @(posedge sys_clk) begin
      mode_s1_q <= {offset_mode_sel_hi, offset_mode_sel_lo};
      mode_s2_q <= mode_s1_q;
   end

   // initialisation sequencer, next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         fifo_pkg::ST_INIT: begin
            // first cycle after release: mode pins decide
            if (fifo_pkg::offset_mode_e'(mode_s2_q) == fifo_pkg::MODE_SER) begin
               st_d = fifo_pkg::ST_SER;
            end else begin
               st_d = fifo_pkg::ST_WAIT;
            end
         end
         fifo_pkg::ST_WAIT: begin
            // two write edges before in-space rises
            if (wr.edge_seen && wait_cnt_q == WAIT_LAST) begin
               st_d = (mode_q == fifo_pkg::MODE_PAR) ? fifo_pkg::ST_PAR : fifo_pkg::ST_RUN;
            end
         end
         fifo_pkg::ST_SER: begin
            // edge after the last bit opens the fifo
            if (wr.edge_seen && ser_cnt_q == SER_LAST) begin
               st_d = fifo_pkg::ST_RUN;
            end
         end
         fifo_pkg::ST_PAR: begin
            if (wr_off_load && par_cnt_q) begin
               st_d = fifo_pkg::ST_RUN;
            end
         end
         fifo_pkg::ST_RUN: st_d = fifo_pkg::ST_RUN;
         default:          st_d = fifo_pkg::ST_INIT;
      endcase
   end

   // sequencer state and its counters
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_q       <= fifo_pkg::ST_INIT;
         mode_q     <= fifo_pkg::MODE_PAR;
         wait_cnt_q <= 2'h0;
      end else begin
         st_q <= st_d;
         if (st_q == fifo_pkg::ST_INIT) begin
            mode_q <= fifo_pkg::offset_mode_e'(mode_s2_q);
         end
         if (st_q == fifo_pkg::ST_WAIT && wr.edge_seen) begin
            wait_cnt_q <= wait_cnt_q + 2'h1;
         end
      end
   end

   // offset registers: preset, parallel or serial load
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         off_ae_q  <= '0;
         off_af_q  <= '0;
         par_cnt_q <= 1'b0;
         ser_cnt_q <= '0;
      end else if (st_q == fifo_pkg::ST_INIT) begin
         // presets are loaded into both registers at once
         if (fifo_pkg::offset_mode_e'(mode_s2_q) == fifo_pkg::MODE_P64) begin
            off_ae_q <= fifo_pkg::PRESET_HI[OFF_W-1:0];
            off_af_q <= fifo_pkg::PRESET_HI[OFF_W-1:0];
         end else if (fifo_pkg::offset_mode_e'(mode_s2_q) == fifo_pkg::MODE_P8) begin
            off_ae_q <= fifo_pkg::PRESET_LO[OFF_W-1:0];
            off_af_q <= fifo_pkg::PRESET_LO[OFF_W-1:0];
         end
      end else if (wr_off_load) begin
         // near-full first, near-empty second, low bus bits
         if (!par_cnt_q) begin
            off_af_q <= wr.ctrl[fifo_pkg::WC_DATA +: OFF_W];
         end else begin
            off_ae_q <= wr.ctrl[fifo_pkg::WC_DATA +: OFF_W];
         end
         par_cnt_q <= 1'b1;
      end else if (st_q == fifo_pkg::ST_SER && wr.edge_seen
                   && !wr.ctrl[fifo_pkg::WC_SLOAD] && ser_cnt_q != SER_LAST) begin
         // shift chain runs near-full msb through near-empty lsb
         {off_af_q, off_ae_q} <= {off_af_q[OFF_W-2:0], off_ae_q, wr.ctrl[fifo_pkg::WC_SDATA]};
         ser_cnt_q            <= ser_cnt_q + SCNT_W'(1);
      end
   end

   // memory write and write pointer
   always_ff @(posedge sys_clk) begin
      if (wr_store) begin
         mem_q[wptr_q[ADDR_W-1:0]] <= wr.ctrl[fifo_pkg::WC_DATA +: fifo_pkg::DATA_W];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wptr_q <= '0;
      end else begin
         wptr_q <= wptr_d;
      end
   end

   // write-side flags: read pointer stage, then the flag stage
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rptr_w1_q   <= '0;
         in_space_q  <= 1'b0;
         near_full_q <= fifo_pkg::NEAR_FULL_RST;
      end else if (wr.edge_seen) begin
         // two write edges from a read to the flag
         rptr_w1_q   <= rptr_q;
         in_space_q  <= (st_d == fifo_pkg::ST_PAR || st_d == fifo_pkg::ST_RUN)
                        && (fill_w != DEPTH_P);
         near_full_q <= !(fill_w >= DEPTH_P - {1'b0, off_af_q});
      end
   end

   // read side: write pointer stages, out-ready and near-empty flags, read pointer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wptr_r1_q    <= '0;
         wptr_r2_q    <= '0;
         rptr_q       <= '0;
         out_ready_q  <= 1'b0;
         near_empty_q <= fifo_pkg::NEAR_EMPTY_RST;
      end else if (rd.edge_seen) begin
         // third read edge after a write shows the word
         wptr_r1_q    <= wptr_q;
         wptr_r2_q    <= wptr_r1_q;
         rptr_q       <= rptr_d;
         near_empty_q <= (fill_r > {1'b0, off_ae_q});
         if (rd_adv) begin
            out_ready_q <= 1'b1;
         end else if (rd_qual) begin
            out_ready_q <= 1'b0;
         end
      end
   end

   // output register holds the last word while out-ready is low
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dout_q <= '0;
      end else if (rd_adv) begin
         dout_q <= mem_q[rptr_q[ADDR_W-1:0]];
      end
   end

   // bus drive: sampled select and direction pins only, so drive follows pins three flops late
   assign wport_bus_oe = !wr.ctrl[fifo_pkg::WC_SEL_N] && !wr.ctrl[fifo_pkg::WC_DIR];
   assign rport_bus_oe = !rd.ctrl[fifo_pkg::RC_SEL_N] && rd.ctrl[fifo_pkg::RC_DIR];
   // mailbox registers live outside; the write bus shows an idle word
   assign wport_bus_o  = fifo_pkg::WPORT_IDLE;
   assign rport_bus_o  = dout_q;

   assign in_space_flag       = in_space_q;
   assign near_full_flag      = near_full_q;
   assign out_ready_flag      = out_ready_q;
   assign near_empty_flag     = near_empty_q;
   assign mail_to_reader_flag = fifo_pkg::MAIL_FLAG_RST;
   assign mail_to_writer_flag = fifo_pkg::MAIL_FLAG_RST;

   // checks
   // first cycle out of reset with either preset chosen
   sequence s_init_preset;
      st_q == fifo_pkg::ST_INIT && nrst
      && (mode_s2_q == fifo_pkg::MODE_P64 || mode_s2_q == fifo_pkg::MODE_P8);
   endsequence

   sequence s_last_serial_edge;
      st_q == fifo_pkg::ST_SER && wr.edge_seen && ser_cnt_q == SER_LAST;
   endsequence

   property p_preset_load;
      @(posedge sys_clk) disable iff (!nrst)
      s_init_preset |=> off_af_q == off_ae_q && !in_space_q
                        && off_ae_q == (($past(mode_s2_q) == fifo_pkg::MODE_P64)
                                        ? fifo_pkg::PRESET_HI[OFF_W-1:0]
                                        : fifo_pkg::PRESET_LO[OFF_W-1:0]);
   endproperty
   a_preset_load: assert property (p_preset_load) else $error("preset not loaded");

   property p_serial_done;
      @(posedge sys_clk) disable iff (!nrst)
      s_last_serial_edge |=> in_space_q && st_q == fifo_pkg::ST_RUN;
   endproperty
   a_serial_done: assert property (p_serial_done) else $error("no space after load");

   property p_serial_low;
      @(posedge sys_clk) disable iff (!nrst)
      st_q == fifo_pkg::ST_SER |-> !in_space_q && ser_cnt_q <= SER_LAST;
   endproperty
   a_serial_low: assert property (p_serial_low) else $error("space during load");

   property p_par_no_store;
      @(posedge sys_clk) disable iff (!nrst)
      wr_qual && st_q == fifo_pkg::ST_PAR |-> !wr_store ##1 wptr_q == $past(wptr_q);
   endproperty
   a_par_no_store: assert property (p_par_no_store) else $error("offset write stored");

   property p_write_step;
      @(posedge sys_clk) disable iff (!nrst)
      wr_store |=> wptr_q == $past(wptr_q) + PTR_W'(1) && !wport_bus_oe;
   endproperty
   a_write_step: assert property (p_write_step) else $error("write pointer step");

   property p_full_refuse;
      @(posedge sys_clk) disable iff (!nrst)
      !in_space_q |=> wptr_q == $past(wptr_q);
   endproperty
   a_full_refuse: assert property (p_full_refuse) else $error("write while full");

   property p_read_step;
      @(posedge sys_clk) disable iff (!nrst)
      rd_adv |=> out_ready_q && rptr_q == $past(rptr_q) + PTR_W'(1);
   endproperty
   a_read_step: assert property (p_read_step) else $error("read step lost");

   property p_hold_word;
      @(posedge sys_clk) disable iff (!nrst)
      !out_ready_q && !rd_adv |=> $stable(dout_q) && rptr_q == $past(rptr_q);
   endproperty
   a_hold_word: assert property (p_hold_word) else $error("word changed while idle");

   property p_ready_needs_sync;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(out_ready_q) |-> $past(wptr_r2_q) != $past(rptr_q);
   endproperty
   a_ready_needs_sync: assert property (p_ready_needs_sync) else $error("ready too early");

   property p_init_flags;
      @(posedge sys_clk) disable iff (!nrst)
      st_q == fifo_pkg::ST_INIT |-> !in_space_q && !out_ready_q && near_full_q && !near_empty_q;
   endproperty
   a_init_flags: assert property (p_init_flags) else $error("flags after reset");

endmodule : dual_clock_fifo_offset_flags

`default_nettype wire

// ===== test/port_masters.sv
/* free-running port clocks of the two far-side masters.
   assumes: sys_clk at 40 MHz drives this model. */
`default_nettype none
module port_masters (
   input  wire logic sys_clk,
   output var logic  wclk,
   output var logic  rclk
);
   timeunit 1ns;
   timeprecision 100ps;
   int wc = 0;   // write half-period count
   int rc = 0;   // read half-period count
   initial wclk = 1'h0;
   initial rclk = 1'h0;
   // unequal rates so the two ports slip past each other
   always @(posedge sys_clk) begin
      wc <= (wc == 3) ? 0 : wc + 1;
      rc <= (rc == 4) ? 0 : rc + 1;
      if (wc == 3) wclk <= ~wclk;
      if (rc == 4) rclk <= ~rclk;
   end
endmodule : port_masters
`default_nettype wire

// ===== test/dual_clock_fifo_offset_flags_tb.sv
/* self-checking bench: presets, parallel offset load, bus drive.
   assumes: port_masters supplies both port clocks. */
`default_nettype none
module dual_clock_fifo_offset_flags_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 0, nrst = 0, mode_hi = 0, mode_lo = 0;
   logic ws_n = 1, wdir = 0, wen = 0, rs_n = 1, rdir = 0, ren = 0;
   logic [35:0] wd = 0;
   wire logic [35:0] rq, wq;
   wire logic wclk, rclk, woe, roe, isp, nfl, ordy, nem, m1, m2;
   int miscompares = 0;
   int comparisons = 0;
   port_masters pm (.sys_clk(sys_clk), .wclk(wclk), .rclk(rclk));
   dual_clock_fifo_offset_flags dut (.sys_clk(sys_clk), .nrst(nrst),
      .write_side_clock(wclk), .read_side_clock(rclk), .offset_mode_sel_hi(mode_hi),
      .offset_mode_sel_lo(mode_lo), .serial_load_n(mode_hi), .serial_offset_in(mode_lo),
      .wport_select_n(ws_n), .wport_dir(wdir), .wport_xfer_en(wen),
      .wport_mailbox_sel(1'h0), .wport_bus_i(wd), .wport_bus_o(wq), .wport_bus_oe(woe),
      .rport_select_n(rs_n), .rport_dir(rdir), .rport_xfer_en(ren),
      .rport_mailbox_sel(1'h0), .rport_bus_i(36'h0_0000_0000), .rport_bus_o(rq),
      .rport_bus_oe(roe), .in_space_flag(isp), .near_full_flag(nfl),
      .out_ready_flag(ordy), .near_empty_flag(nem), .mail_to_reader_flag(m1),
      .mail_to_writer_flag(m2));
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   // long reset so both port clocks see at least four edges
   task automatic rst(input logic [1:0] m, input logic sp);
      nrst <= 0;
      {mode_hi, mode_lo} <= m;
      repeat (45) @(posedge sys_clk);
      chk("in_space", 0, isp);
      chk("out_ready", 0, ordy);
      chk("nf_ne_m1_m2", 4'hb, {nfl, nem, m1, m2});
      // release with the write clock low, so no edge is half seen
      @(negedge wclk);
      @(posedge sys_clk) nrst <= 1;
      @(posedge wclk);
      repeat (4) @(posedge sys_clk);
      chk("in_space", 0, isp);
      @(posedge wclk);
      repeat (4) @(posedge sys_clk);
      chk("in_space", sp, isp);
   endtask : rst
   // controls change at the falling port edge, only the enable dropped after
   task automatic wr(input logic [35:0] d);
      @(negedge wclk);
      @(posedge sys_clk) {ws_n, wdir, wen, wd} <= {3'h3, d};
      @(negedge wclk);
      @(posedge sys_clk) wen <= 0;
   endtask : wr
   task automatic rd();
      @(negedge rclk);
      @(posedge sys_clk) {rs_n, rdir, ren} <= 3'h3;
      @(negedge rclk);
      @(posedge sys_clk) ren <= 0;
   endtask : rd
   task automatic settle();
      repeat (5) @(negedge rclk);
      repeat (4) @(posedge sys_clk);
   endtask : settle
   task automatic t_preset();
      rst(2'h1, 1'b1);
      for (int i = 0; i < 3; i++) wr(36'h1_2345_0000 + 36'(i));
      for (int i = 0; i < 3; i++) begin
         settle();
         chk("out_ready", 1, ordy);
         chk("rdata", 36'h1_2345_0000 + 36'(i), rq);
         rd();
      end
      settle();
      chk("out_ready", 0, ordy);
      chk("rdata", 36'h1_2345_0002, rq);
      $display("test preset done");
   endtask : t_preset
   // first two writes are offsets and must never reach the reader
   task automatic t_parallel();
      rst(2'h0, 1'b1);
      wr(36'h0_0000_0010);
      wr(36'h0_0000_0020);
      wr(36'h5_a5a5_0f0f);
      settle();
      chk("rdata", 36'h5_a5a5_0f0f, rq);
      $display("test parallel done");
   endtask : t_parallel
   task automatic t_oe();
      rst(2'h2, 1'b1);
      @(posedge sys_clk) wdir <= 0;
      repeat (6) @(posedge sys_clk);
      chk("wport_oe", 1, woe);
      chk("rport_oe", 1, roe);
      @(posedge sys_clk) {ws_n, rs_n} <= 2'h3;
      repeat (6) @(posedge sys_clk);
      chk("wport_oe", 0, woe);
      chk("rport_oe", 0, roe);
      chk("wport_bus", fifo_pkg::WPORT_IDLE, wq);
      $display("test oe done");
   endtask : t_oe
   // one serial bit: enable low across exactly one write edge
   task automatic ser_bit(input logic b);
      @(negedge wclk);
      @(posedge sys_clk) {mode_hi, mode_lo} <= {1'b0, b};
      @(negedge wclk);
      @(posedge sys_clk) mode_hi <= 1'b1;
   endtask : ser_bit
   // near-full 508 then near-empty 1, msb first; a reversed order would give
   // 256 and 127, which flips both near flags checked below
   task automatic t_serial();
      logic [17:0] bits = {9'h1fc, 9'h001};
      rst(2'h3, 1'b0);
      for (int i = 17; i >= 0; i--) ser_bit(bits[i]);
      repeat (2) @(posedge sys_clk);
      chk("in_space", 0, isp);
      @(posedge wclk);
      repeat (4) @(posedge sys_clk);
      chk("in_space", 1, isp);
      for (int i = 0; i < 5; i++) wr(36'h3_0000_0000 + 36'(i));
      settle();
      chk("rdata", 36'h3_0000_0000, rq);
      chk("near_full_empty", 2'h1, {nfl, nem});
      $display("test serial done");
   endtask : t_serial
   initial begin
      t_preset();
      t_parallel();
      t_oe();
      t_serial();
      give_verdict();
   end
   // whole run needs well under 2000 cycles
   initial begin
      #100000;
      miscompares++;
      give_verdict();
   end
endmodule : dual_clock_fifo_offset_flags_tb
`default_nettype wire
